/* trail_id_regs.vh */
// Register offsets, reset values and frame cycle constants for the trail
// identifier insertion block.
// Assumes byte-wide registers, each at one aligned 32-bit AHB word.
`ifndef TRAIL_ID_REGS_VH
`define TRAIL_ID_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define TRAIL_ID_IDX_BYTE_0 8'h38
`define TRAIL_ID_IDX_BYTE_1 8'h39
`define TRAIL_ID_IDX_BYTE_2 8'h3a
`define TRAIL_ID_IDX_BYTE_3 8'h3b
`define TRAIL_ID_IDX_BYTE_4 8'h3c
`define TRAIL_ID_IDX_BYTE_5 8'h3d
`define TRAIL_ID_IDX_BYTE_6 8'h3e
`define TRAIL_ID_IDX_BYTE_7 8'h3f
`define TRAIL_ID_IDX_BYTE_8 8'h40
`define TRAIL_ID_IDX_BYTE_15 8'h47
`define TRAIL_ID_IDX_STATUS 8'h48

// ----------------------------------------
// Reset values and cycle constants
// ----------------------------------------
`define TRAIL_ID_CRC_BYTE_RESET 8'h90
`define TRAIL_ID_BYTE_RESET 8'h00
`define TRAIL_ID_CYCLE_LAST 4'hf

`endif

/* e3_trail_trace_tx_insert.v */
// E3 transmit trail identifier insertion: 16 byte registers on AHB-Lite,
// one byte per outbound frame into the TR overhead position.
// Assumes frame_start is a one-cycle pulse from the framer on hclk.
`include "trail_id_regs.vh"
`default_nettype none

module e3_trail_trace_tx_insert #(
  parameter NUM_BYTES = 16
) (
  // AHB-Lite clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Framer timing
  input wire frame_start,
  // TR byte for the frame now being sent
  output reg [7:0] tr_byte,
  output reg [3:0] cycle_pos
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Maps a byte address to an identifier slot; bit 4 set means unmapped
  function [4:0] slot_of;
    input [31:0] addr;
    reg [29:0] idx;
    begin
      idx = addr[31:2];
      if (addr[1:0] == 2'h0 && idx >= {22'h0, `TRAIL_ID_IDX_BYTE_0} &&
          idx <= {22'h0, `TRAIL_ID_IDX_BYTE_15}) begin
        slot_of = {1'b0, idx[3:0] - 4'h8};
      end else begin
        slot_of = 5'h10;
      end
    end
  endfunction

  reg [7:0] id_byte [0:NUM_BYTES-1];
  reg [7:0] fetched;
  reg wr_pend;
  reg [4:0] wr_slot;
  reg [31:0] next_hrdata;
  wire [4:0] addr_slot;
  wire take;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && htrans[1];
  assign addr_slot = slot_of(haddr);

  // ----------------------------------------
  // Bus side
  // ----------------------------------------
  // Latch write address phase; data lands in the following data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_slot <= 5'h10;
    end else begin
      wr_pend <= take && hwrite;
      wr_slot <= addr_slot;
    end
  end

  // Read data: identifier bytes, cycle_pos in the status word, zero for unmapped words
  always @* begin
    next_hrdata = 32'h0;
    if (!addr_slot[4]) begin
      next_hrdata = {24'h0, id_byte[addr_slot[3:0]]};
    end else if (haddr[31:2] == {22'h0, `TRAIL_ID_IDX_STATUS} && haddr[1:0] == 2'h0) begin
      next_hrdata = {28'h0, cycle_pos};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Identifier byte storage; reset loads 8'h90 into byte 0 and clears the rest
  genvar g;
  generate
    for (g = 0; g < NUM_BYTES; g = g + 1) begin : g_byte
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          id_byte[g] <= (g == 0) ? `TRAIL_ID_CRC_BYTE_RESET : `TRAIL_ID_BYTE_RESET;
        end else if (wr_pend && wr_slot == g) begin
          id_byte[g] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Frame side
  // ----------------------------------------
  // Counter steps per frame; fetch slot k in frame k, send it in the next
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_pos <= 4'h0;
      fetched <= 8'h0;
      tr_byte <= 8'h0;
    end else if (frame_start) begin
      cycle_pos <= (cycle_pos == `TRAIL_ID_CYCLE_LAST) ? 4'h0 : cycle_pos + 4'h1;
      fetched <= id_byte[cycle_pos];
      tr_byte <= fetched;
    end
  end

endmodule // e3_trail_trace_tx_insert
`default_nettype wire

/* tr_chk_props.sv */
// Checker: frame counter and TR byte timing at the block's ports
// Assumes it is bound to the insertion block
`default_nettype none
module tr_chk(input wire logic hclk, input wire logic hresetn, input wire logic frame_start,
  input wire logic hreadyout, input wire logic hresp, input wire logic [7:0] tr_byte,
  input wire logic [3:0] cycle_pos);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pos_step: assert property (frame_start |=> cycle_pos == $past(cycle_pos) + 4'h1)
    else $error("frame counter did not step");
  a_pos_hold: assert property (!frame_start |=> $stable(cycle_pos))
    else $error("frame counter moved");
  a_tr_hold: assert property (!frame_start |=> $stable(tr_byte))
    else $error("tr byte moved");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready");
  // Last frame of the cycle is followed by the first
  sequence s_last_frame; frame_start && cycle_pos == 4'hf; endsequence
  a_pos_wrap: assert property (s_last_frame |=> cycle_pos == 4'h0)
    else $error("frame counter did not wrap");
  a_reset_clear: assert property (disable iff (1'b0) !hresetn |-> cycle_pos == 4'h0 && tr_byte == 8'h00)
    else $error("frame state not cleared in reset");
endmodule // tr_chk
bind e3_trail_trace_tx_insert tr_chk i_chk(.*);
`default_nettype wire

/* far_end.sv */
// Far side: frame pulse source and TR byte capture
// Assumes the framer clock is shared
`default_nettype none
module far_end(input wire logic clk, output logic fs, input wire logic [7:0] tr,
  output logic [7:0] got);
  timeunit 1ns;
  timeprecision 1ns;
  initial fs = 0;
  // One frame: a one-cycle pulse, then take the byte sent
  task frame;
    @(posedge clk) fs <= 1;
    @(posedge clk) fs <= 0;
    #1 got = tr;
  endtask
endmodule // far_end
`default_nettype wire

/* tb_top.sv */
// Testbench: identifier registers over AHB-Lite and the TR sequence
// Assumes the insertion block and the far_end model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hwrite = 0, fs;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [7:0] tr, got;
  logic [7:0] dat[7] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
  wire rdy;
  int errors = 0, cmp_count = 0;
  always #50 hclk = ~hclk;
  e3_trail_trace_tx_insert i_dut(.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy), .hresp(),
    .frame_start(fs), .tr_byte(tr), .cycle_pos());
  far_end i_far(.clk(hclk), .fs, .tr, .got);
  // Single AHB-Lite transfer to register index i
  task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    htrans <= 2'h2; hwrite <= w; haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task complete_run;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    bus(0, 8'h3a, 0); chk("reset", 0, hrdata);
    for (int k = 0; k < 7; k++) bus(1, 8'h3a + k, {24'hffffff, dat[k]});
    for (int k = 0; k < 7; k++) begin
      bus(0, 8'h3a + k, 0); chk("reg", {24'h0, dat[k]}, hrdata);
    end
    $display("register test done");
    for (int k = 0; k < 18; k++) begin
      i_far.frame;
      if (k == 1) chk("tr0", 8'h90, got);
      if (k > 2 && k < 10) chk("tr", dat[k - 3], got);
    end
    $display("frame test done");
    complete_run;
  end
  // Watchdog
  initial begin
    #200000;
    errors++;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
